/* File: src/rtccs_map.vh */
// Register offsets, field positions, reset values and timing counts for the
// clock control and status block. Definitions only; included by bare name.
`ifndef RTCCS_MAP_VH
`define RTCCS_MAP_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define RTCCS_CTRL_OFS      8'h00
`define RTCCS_STATUS_OFS    8'h04
`define RTCCS_KEY0_OFS      8'h08
`define RTCCS_KEY1_OFS      8'h0c

// ************************************************************
// Control fields
// ************************************************************
`define RTCCS_CTRL_ISO      7
`define RTCCS_CTRL_DIS      6
`define RTCCS_CTRL_LOAD     5
`define RTCCS_CTRL_H12      3
`define RTCCS_CTRL_COMP     2
`define RTCCS_CTRL_ROUND    1
`define RTCCS_CTRL_RUN      0
`define RTCCS_CTRL_RST      8'h00
`define RTCCS_CTRL_RDMASK   8'h6f

// ************************************************************
// Status fields
// ************************************************************
`define RTCCS_ST_ALARM      6
`define RTCCS_ST_DAY        5
`define RTCCS_ST_HOUR       4
`define RTCCS_ST_MIN        3
`define RTCCS_ST_SEC        2
`define RTCCS_ST_RUN        1
`define RTCCS_ST_BUSY       0
`define RTCCS_ST_RSVD       16'hff80

// ************************************************************
// Unlock keys (arbitrary values) and timing
// ************************************************************
`define RTCCS_KEY0_VAL      32'h1234_5678
`define RTCCS_KEY1_VAL      32'h9abc_def0
`define RTCCS_BUSY_NS       15000
`define RTCCS_CLK_NS        40
`define RTCCS_BUSY_CYC      ((`RTCCS_BUSY_NS + `RTCCS_CLK_NS - 1) / `RTCCS_CLK_NS)

`endif

/* File: src/rtccs_regs.v */
// Control and status registers of the real-time clock, Avalon-MM slave.
// Assumes the time counter core sits outside, on inputs synchronous to clk;
// the 32 kHz reference arrives as a synchronous tick input.
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "rtccs_map.vh"

module rtccs_regs #(
    parameter BUSY_CYC = `RTCCS_BUSY_CYC
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Avalon-MM slave
    input  wire [7:0]  avsAddress,
    input  wire        avsRead,
    input  wire        avsWrite,
    input  wire [31:0] avsWriteData,
    input  wire [3:0]  avsByteEnable,
    output reg  [31:0] avsReadData,
    output reg         avsWaitRequest,
    output reg  [1:0]  avsResponse,
    // Time core
    input  wire        refTick,
    input  wire        updatePending,
    input  wire        updateActive,
    input  wire        timerEnable,
    input  wire        dayInc,
    input  wire        hourInc,
    input  wire        minuteInc,
    input  wire        secondInc,
    input  wire        alarmEvent,
    input  wire        timeRegRead,
    // Control outputs
    output reg         isolationEnable,
    output reg         refTickGated,
    output reg         subsecondCounterLoad,
    output reg         twelveHourSelect,
    output reg         autoDriftCorrection,
    output reg         minuteRounding,
    output reg         counterAdvance
);

    // ************************************************************
    // Register state
    // ************************************************************
    reg  [7:0]  ctrl_q;
    reg  [7:0]  ctrlSync1_q;
    reg  [7:0]  ctrlSync2_q;
    reg  [1:0]  keyOk_q;
    reg         alarmFlag_q;
    reg  [3:0]  rollFlags_q;
    reg  [13:0] busyCnt_q;
    reg         busy_q;
    reg         runStatus_q;
    reg         ack_q;

    // ************************************************************
    // Decode and packing helpers
    // ************************************************************
    // Full-word address compare; every register owns one word
    function addrIs;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            addrIs = (addr == ofs);
        end
    endfunction

    // Key compare; the caller also demands all four byte lanes
    function keyMatch;
        input [31:0] data;
        input [31:0] key;
        begin
            keyMatch = (data == key);
        end
    endfunction

    // Reserved status bits read as one
    function [15:0] statusPack;
        input       alarm;
        input [3:0] roll;
        input       run;
        input       busy;
        begin
            statusPack = `RTCCS_ST_RSVD | {9'h000, alarm, roll, run, busy};
        end
    endfunction

    // Isolation enable and the spare bit always read back as zero
    function [31:0] ctrlReadback;
        input [7:0] ctrl;
        begin
            ctrlReadback = {24'h000000, ctrl & `RTCCS_CTRL_RDMASK};
        end
    endfunction

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire        access   = (avsRead | avsWrite) & ~ack_q;
    wire        wrDo     = avsWrite & ~ack_q;
    wire        unlocked = &keyOk_q;
    wire        lane0    = avsByteEnable[0];
    wire        ctrlHit  = addrIs(avsAddress, `RTCCS_CTRL_OFS);
    wire        stHit    = addrIs(avsAddress, `RTCCS_STATUS_OFS);
    wire        key0Hit  = addrIs(avsAddress, `RTCCS_KEY0_OFS);
    wire        key1Hit  = addrIs(avsAddress, `RTCCS_KEY1_OFS);
    wire        mapped   = ctrlHit | stHit | key0Hit | key1Hit;
    // Locked writes are still answered, they just change nothing
    wire        ctrlWrOk = wrDo & ctrlHit & lane0 & unlocked;
    wire        stWrOk   = wrDo & stHit & lane0 & unlocked;
    wire [15:0] statusWord = statusPack(alarmFlag_q, rollFlags_q, runStatus_q, busy_q);

    // Read word, chosen before the answer edge registers it
    reg  [31:0] rdWord;
    always @* begin
        rdWord = 32'h0000_0000;
        if (ctrlHit)
            rdWord = ctrlReadback(ctrl_q);
        else if (stHit)
            rdWord = {16'h0000, statusWord};
    end

    // ************************************************************
    // Effective controls past the crossing
    // ************************************************************
    // Disable outranks load and run, so a parked module never moves
    wire        syncDis  = ctrlSync2_q[`RTCCS_CTRL_DIS];
    wire        syncRun  = ctrlSync2_q[`RTCCS_CTRL_RUN] & ~syncDis;
    wire        syncLoad = ctrlSync2_q[`RTCCS_CTRL_LOAD] & ~syncDis;

    // ************************************************************
    // Bus handshake: one wait cycle, answer on the second edge
    // ************************************************************
    always @(posedge clk) begin
        if (rst) begin
            ack_q          <= 1'b0;
            avsWaitRequest <= 1'b1;
            avsReadData    <= 32'h0000_0000;
            avsResponse    <= 2'h0;
        end else begin
            ack_q          <= access;
            avsWaitRequest <= ~access;
            avsResponse    <= (access & ~mapped) ? 2'h2 : 2'h0;
            if (access & avsRead)
                avsReadData <= rdWord;
        end
    end

    // ************************************************************
    // Unlock keys
    // ************************************************************
    always @(posedge clk) begin
        if (rst) begin
            keyOk_q <= 2'h0;
        end else if (wrDo && avsByteEnable == 4'hf) begin
            // A wrong key relocks; only whole-word writes count
            if (key0Hit)
                keyOk_q[0] <= keyMatch(avsWriteData, `RTCCS_KEY0_VAL);
            if (key1Hit)
                keyOk_q[1] <= keyMatch(avsWriteData, `RTCCS_KEY1_VAL);
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    always @(posedge clk) begin
        if (rst) begin
            ctrl_q <= `RTCCS_CTRL_RST;
        end else begin
            // Write wins over the self-clear of minute rounding
            if (ctrlWrOk)
                ctrl_q <= avsWriteData[7:0] & 8'hef;
            else if (timeRegRead && ctrlSync2_q[`RTCCS_CTRL_ROUND])
                ctrl_q[`RTCCS_CTRL_ROUND] <= 1'b0;
        end
    end

    // Two-stage crossing toward the reference side
    always @(posedge clk) begin
        if (rst) begin
            ctrlSync1_q <= `RTCCS_CTRL_RST;
            ctrlSync2_q <= `RTCCS_CTRL_RST;
        end else begin
            ctrlSync1_q <= ctrl_q;
            ctrlSync2_q <= ctrlSync1_q;
        end
    end

    // ************************************************************
    // Power controls
    // ************************************************************
    // Isolation follows the written bit even though it never reads back
    always @(posedge clk) begin
        if (rst) begin
            isolationEnable <= 1'b0;
            refTickGated    <= 1'b0;
        end else begin
            isolationEnable <= ctrlSync2_q[`RTCCS_CTRL_ISO];
            refTickGated    <= refTick & ~syncDis;
        end
    end

    // ************************************************************
    // Time format and correction controls
    // ************************************************************
    always @(posedge clk) begin
        if (rst) begin
            twelveHourSelect    <= 1'b0;
            autoDriftCorrection <= 1'b0;
            minuteRounding      <= 1'b0;
        end else begin
            twelveHourSelect    <= ctrlSync2_q[`RTCCS_CTRL_H12];
            autoDriftCorrection <= ctrlSync2_q[`RTCCS_CTRL_COMP];
            minuteRounding      <= ctrlSync2_q[`RTCCS_CTRL_ROUND];
        end
    end

    // ************************************************************
    // Counting controls
    // ************************************************************
    // Load holds the sub-second count; the counter waits until it drops
    always @(posedge clk) begin
        if (rst) begin
            subsecondCounterLoad <= 1'b0;
            counterAdvance       <= 1'b0;
            runStatus_q          <= 1'b0;
        end else begin
            subsecondCounterLoad <= syncLoad;
            // Load and disable both hold time still
            counterAdvance       <= refTick & syncRun & ~syncLoad;
            runStatus_q          <= syncRun;
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    always @(posedge clk) begin
        if (rst) begin
            alarmFlag_q <= 1'b0;
        end else begin
            // Set wins over a same-cycle clear
            if (alarmEvent)
                alarmFlag_q <= 1'b1;
            else if (stWrOk && avsWriteData[`RTCCS_ST_ALARM])
                alarmFlag_q <= 1'b0;
        end
    end

    // ************************************************************
    // Rollover flags
    // ************************************************************
    // Reloaded at every update, so each flag reflects only the latest one
    always @(posedge clk) begin
        if (rst) begin
            rollFlags_q <= 4'h0;
        end else if (updateActive) begin
            rollFlags_q <= timerEnable ? {dayInc, hourInc, minuteInc, secondInc} : 4'h0;
        end
    end

    // ************************************************************
    // Busy flag
    // ************************************************************
    // Busy stays up for the guard time after the core warns of an update
    // The counter reloads for as long as the warning stands
    always @(posedge clk) begin
        if (rst) begin
            busyCnt_q <= 14'h0000;
            busy_q    <= 1'b0;
        end else begin
            if (updatePending | updateActive)
                busyCnt_q <= BUSY_CYC[13:0];
            else if (busyCnt_q != 14'h0000)
                busyCnt_q <= busyCnt_q - 14'h0001;
            busy_q <= updatePending | updateActive | (busyCnt_q != 14'h0000);
        end
    end

endmodule

/* File: verification/rtccs_regs_assertions.sv */
// Checker for rtccs_regs: bus answer timing and control effects.
// Sees only the block's ports; bound at the foot of this file.
`timescale 1ns/1ps
`include "rtccs_map.vh"
module rtccs_regs_assertions (
    // Clock, reset, bus
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  avsAddress,
    input wire logic        avsRead,
    input wire logic        avsWrite,
    input wire logic [31:0] avsReadData,
    input wire logic        avsWaitRequest,
    input wire logic [1:0]  avsResponse,
    // Tick and control
    input wire logic        refTick,
    input wire logic        refTickGated,
    input wire logic        counterAdvance,
    input wire logic        subsecondCounterLoad,
    input wire logic        twelveHourSelect
);
    // Six edges of write history: outputs follow a write three edges late
    logic [5:0] ctrlWr_q;
    always @(posedge clk) begin
        ctrlWr_q <= {ctrlWr_q[4:0], avsWrite && avsAddress == `RTCCS_CTRL_OFS};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_ansOne; !avsWaitRequest |=> avsWaitRequest; endproperty
    a_ansOne: assert property (p_ansOne) else $error("answer too long");
    property p_ansNext; (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest; endproperty
    a_ansNext: assert property (p_ansNext) else $error("no answer");
    property p_ctrlRd; !avsWaitRequest && $past(avsRead && avsAddress == `RTCCS_CTRL_OFS)
        |-> avsReadData[31:7] == 25'h0 && !avsReadData[4]; endproperty
    a_ctrlRd: assert property (p_ctrlRd) else $error("bad control read");
    property p_stRd; !avsWaitRequest && $past(avsRead && avsAddress == `RTCCS_STATUS_OFS)
        |-> avsReadData[15:7] == 9'h1ff; endproperty
    a_stRd: assert property (p_stRd) else $error("bad status read");
    property p_unmap; !avsWaitRequest && $past(avsRead && avsAddress > `RTCCS_KEY1_OFS)
        |-> avsResponse == 2'h2 && avsReadData == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
    property p_gate; refTickGated |-> $past(refTick); endproperty
    a_gate: assert property (p_gate) else $error("gated tick without tick");
    property p_load; subsecondCounterLoad && $past(subsecondCounterLoad) |-> !counterAdvance; endproperty
    a_load: assert property (p_load) else $error("advance while loading");
    property p_ctlChg; $changed(twelveHourSelect) |-> ctrlWr_q != 6'h0; endproperty
    a_ctlChg: assert property (p_ctlChg) else $error("control changed without write");
    c_gateOff: cover property ($past(refTick) && !refTickGated);
    c_adv: cover property (counterAdvance);
    c_unmap: cover property (avsResponse == 2'h2);
endmodule

bind rtccs_regs rtccs_regs_assertions rtccs_regs_assertions_i (.*);

/* File: verification/tb.sv */
// Bench for rtccs_regs: bus tasks queue expected answers, a monitor checks them.
// Assumes the register map header and a one-wait-cycle slave.
`timescale 1ns/1ps
`include "rtccs_map.vh"
module tb;
    localparam logic [7:0] CT = `RTCCS_CTRL_OFS;
    localparam logic [7:0] ST = `RTCCS_STATUS_OFS;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic [7:0]  avsAddress = '0;
    logic        avsRead = '0, avsWrite = '0;
    logic [31:0] avsWriteData = '0;
    logic [3:0]  avsByteEnable = 4'hf;
    logic [31:0] avsReadData;
    logic        avsWaitRequest;
    logic [1:0]  avsResponse;
    logic        refTick = '0, updatePending = '0, updateActive = '0, timerEnable = '0, alarmEvent = '0;
    logic        dayInc = '0, hourInc = '0, minuteInc = '0, secondInc = '0, timeRegRead = '0;
    logic        isolationEnable, refTickGated, subsecondCounterLoad, twelveHourSelect;
    logic        autoDriftCorrection, minuteRounding, counterAdvance;
    logic [65:0] expQ[$];
    logic [65:0] e;
    logic [7:0]  v;
    logic [3:0]  rv;
    int          bad_count = 0, cmp_count = 0, cyc = 0, advCnt = 0, gateCnt = 0;
    rtccs_regs #(.BUSY_CYC(4)) rtccs_regs_i (.*);
    always #20 clk = ~clk;
    task chk(input logic ok);
        cmp_count++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("ERROR %0t: mismatch", $time);
        end
    endtask
    task conclude();
        $display("compares %0d errors %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Writes expect no data: mask 0
    task bus(input logic rd, input logic [7:0] a, input logic [31:0] d, m, input logic [1:0] r = 2'h0);
        expQ.push_back({r, m, d & m});
        avsAddress <= a;
        avsRead <= rd;
        avsWrite <= !rd;
        avsWriteData <= d;
        @(posedge clk);
        while (avsWaitRequest !== 1'b0) @(posedge clk);
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge clk);
    endtask
    task ticks(input int ea, eg);
        int a0, g0;
        repeat (4) @(posedge clk);
        a0 = advCnt;
        g0 = gateCnt;
        repeat (5) begin
            refTick <= 1'b1;
            @(posedge clk);
            refTick <= 1'b0;
            @(posedge clk);
        end
        repeat (2) @(posedge clk);
        chk(advCnt - a0 == ea && gateCnt - g0 == eg);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        advCnt <= advCnt + (counterAdvance === 1'b1);
        gateCnt <= gateCnt + (refTickGated === 1'b1);
        if (cyc == 3000) begin
            bad_count++;
            conclude();
        end
        if (avsWaitRequest === 1'b0 && expQ.size() > 0) begin
            e = expQ.pop_front();
            chk((avsReadData & e[63:32]) === e[31:0] && avsResponse === e[65:64]);
        end
    end
    initial begin
        void'($urandom(32'h36e1dccc));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1, ST, 32'hff80, '1);
        bus(0, CT, 32'hff, 0);
        alarmEvent <= 1'b1;
        @(posedge clk);
        alarmEvent <= 1'b0;
        bus(0, ST, 32'h40, 0);
        bus(1, CT, 32'h0, '1);
        bus(1, ST, 32'hffc0, 32'hffff);
        bus(0, `RTCCS_KEY0_OFS, `RTCCS_KEY0_VAL, 0);
        bus(0, `RTCCS_KEY1_OFS, `RTCCS_KEY1_VAL, 0);
        bus(1, 8'h10, 32'h0, '1, 2'h2);
        bus(0, ST, 32'h0, 0);
        bus(1, ST, 32'h40, 32'h40);
        bus(0, ST, 32'h40, 0);
        bus(1, ST, 32'h0, 32'h40);
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom) | (8'h1 << i);
            bus(0, CT, {24'h0, v}, 0);
            bus(1, CT, {24'h0, v & 8'h6f}, '1);
            repeat (4) @(posedge clk);
            chk(isolationEnable === v[7]);
            chk(subsecondCounterLoad === (v[5] & !v[6]));
            chk(twelveHourSelect === v[3]);
            chk(autoDriftCorrection === v[2]);
            chk(minuteRounding === v[1]);
            bus(1, ST, {30'h0, v[0] & !v[6], 1'b0}, 32'h3);
        end
        bus(0, CT, 32'h1, 0);
        ticks(5, 5);
        bus(0, CT, 32'h21, 0);
        ticks(0, 5);
        bus(0, CT, 32'h1, 0);
        ticks(5, 5);
        bus(0, CT, 32'h0, 0);
        ticks(0, 5);
        bus(0, CT, 32'h2, 0);
        timeRegRead <= 1'b1;
        @(posedge clk);
        timeRegRead <= 1'b0;
        repeat (4) @(posedge clk);
        chk(minuteRounding === 1'b0);
        updatePending <= 1'b1;
        repeat (6) @(posedge clk);
        bus(1, ST, 32'h1, 32'h1);
        updatePending <= 1'b0;
        repeat (12) @(posedge clk);
        bus(1, ST, 32'h0, 32'h1);
        for (int t = 1; t >= 0; t--) begin
            rv = 4'($urandom);
            timerEnable <= t[0];
            {dayInc, hourInc, minuteInc, secondInc} <= rv;
            updateActive <= 1'b1;
            @(posedge clk);
            updateActive <= 1'b0;
            repeat (12) @(posedge clk);
            bus(1, ST, {26'h0, rv & {4{t[0]}}, 2'h0}, 32'h3c);
        end
        bus(0, CT, 32'h41, 0);
        ticks(0, 0);
        conclude();
    end
endmodule
